/* File: design/pspr_port.sv */
// SPI slave port with paged 8-bit register space
`timescale 1ns/1ps
`default_nettype none
module pspr_port (
    input wire logic clk_i,                          // Core clock
    input wire logic nrst_i,                         // Async reset, low
    input wire logic addr_bit0_or_serial_clock_pin_i, // Serial clock
    input wire logic twowire_data_or_select_pin_i,   // chip_select_n
    input wire logic clock_or_host_out_pin_i,        // Host-out data
    output logic addr_bit1_or_host_in_pin_o,         // Host-in data
    output logic addr_bit1_or_host_in_pin_oe_o,      // Host-in enable
    output logic wr_valid_o,                         // Register written
    output pspr_pkg::pspr_wr_t wr_o,                 // Written register
    output logic [7:0] page_o,                       // Current page
    output logic soft_reset_o,                       // Software reset
    output pspr_pkg::pspr_mode_t mode_o              // Detected protocol
);
    logic sclk;
    logic chip_select_n;
    logic frame_rst_n;
    logic [7:0] mem [pspr_pkg::MEM_DEPTH];

    pspr_pkg::pspr_frame_t frm;
    pspr_pkg::pspr_frame_t next_frm;
    pspr_pkg::pspr_keep_t keep;
    pspr_pkg::pspr_keep_t next_keep;
    pspr_pkg::pspr_tx_t tx;
    pspr_pkg::pspr_tx_t next_tx;
    pspr_pkg::pspr_core_t core;
    pspr_pkg::pspr_core_t next_core;

    logic [7:0] rx_byte;
    logic byte_done;
    logic mem_we;
    logic [8:0] mem_waddr;
    logic [2:0] wr_slot;
    logic [2:0] pins_s;
    logic wr_tgl_s;
    logic rst_tgl_s;

    // Map a page to its storage slot; only pages 0, 2, 3, 4 exist
    function automatic logic [2:0] slot_of(input logic [7:0] page);
        logic [2:0] s;
        s = 3'h0;
        unique case (page)
            pspr_pkg::CFG_PAGE: s = 3'h4;
            pspr_pkg::COEF_PAGE_A: s = 3'h5;
            pspr_pkg::COEF_PAGE_B: s = 3'h6;
            pspr_pkg::COEF_PAGE_C: s = 3'h7;
            default: s = 3'h0;
        endcase
        return s;
    endfunction

    // Register read in the current page
    function automatic logic [7:0] rd_byte(input logic [7:0] page,
                                           input logic [6:0] addr);
        logic [2:0] s;
        logic [7:0] v;
        s = slot_of(page);
        v = pspr_pkg::READ_FILL;
        if (addr == pspr_pkg::PAGE_REG_ADDR) begin
            v = page;
        end else if (s[2]) begin
            v = mem[{s[1:0], addr}];
        end
        return v;
    endfunction

    assign sclk = addr_bit0_or_serial_clock_pin_i;
    assign chip_select_n = twowire_data_or_select_pin_i;
    // Select high ends the frame without needing a clock edge
    assign frame_rst_n = nrst_i & ~chip_select_n;

    assign rx_byte = {frm.shreg, clock_or_host_out_pin_i};
    assign byte_done = (frm.bitcnt == pspr_pkg::LAST_BIT);

    // Receive side, sampled on the falling edge
    always_comb begin
        next_frm = frm;
        next_frm.bitcnt = frm.bitcnt + 3'h1;
        next_frm.shreg = rx_byte[6:0];
        if (byte_done) begin
            unique case (frm.phase)
                pspr_pkg::PSPR_PH_CMD: begin
                    next_frm.addr = rx_byte[7:1];
                    next_frm.phase = rx_byte[pspr_pkg::CMD_DIR_BIT]
                        ? pspr_pkg::PSPR_PH_RD : pspr_pkg::PSPR_PH_WR;
                end
                pspr_pkg::PSPR_PH_WR,
                pspr_pkg::PSPR_PH_RD: begin
                    next_frm.addr = frm.addr + 7'h1;
                end
            endcase
        end
    end

    always_ff @(negedge sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            frm <= '{phase: pspr_pkg::PSPR_PH_CMD, bitcnt: 3'h0,
                     shreg: 7'h00, addr: 7'h00};
        end else begin
            frm <= next_frm;
        end
    end

    assign wr_slot = slot_of(keep.page);

    // Register writes and page selection
    always_comb begin
        next_keep = keep;
        mem_we = 1'b0;
        mem_waddr = {wr_slot[1:0], frm.addr};
        if (byte_done && frm.phase == pspr_pkg::PSPR_PH_WR) begin
            next_keep.wr = '{page: keep.page, addr: frm.addr,
                             data: rx_byte};
            next_keep.wr_tgl = ~keep.wr_tgl;
            if (frm.addr == pspr_pkg::PAGE_REG_ADDR) begin
                next_keep.page = rx_byte;
            end else if (keep.page == pspr_pkg::CFG_PAGE &&
                         frm.addr == pspr_pkg::SWRST_ADDR &&
                         rx_byte[pspr_pkg::SWRST_BIT]) begin
                next_keep.page = pspr_pkg::PAGE_RESET;
                next_keep.rst_tgl = ~keep.rst_tgl;
            end else begin
                mem_we = wr_slot[2];
            end
        end
    end

    always_ff @(negedge sclk or negedge nrst_i) begin
        if (!nrst_i) begin
            keep <= '{page: pspr_pkg::PAGE_RESET, wr: '0,
                      wr_tgl: 1'b0, rst_tgl: 1'b0};
        end else begin
            keep <= next_keep;
        end
    end

    // Register storage for the configuration and coefficient pages
    always_ff @(negedge sclk) begin
        if (mem_we) begin
            mem[mem_waddr] <= rx_byte;
        end
    end

    // Transmit side, driven on the rising edge
    always_comb begin
        next_tx = tx;
        next_tx.oe = 1'b1;
        if (frm.phase == pspr_pkg::PSPR_PH_RD && frm.bitcnt == 3'h0) begin
            next_tx.byte_sh = rd_byte(keep.page, frm.addr);
        end else begin
            next_tx.byte_sh = {tx.byte_sh[6:0], 1'b0};
        end
    end

    always_ff @(posedge sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            tx <= '{byte_sh: 8'h00, oe: 1'b0};
        end else begin
            tx <= next_tx;
        end
    end

    assign addr_bit1_or_host_in_pin_o = tx.byte_sh[7];
    assign addr_bit1_or_host_in_pin_oe_o = tx.oe;

    // Core clock side: pins and event toggles cross by two flops
    pspr_sync #(.W(3)) u_pin_sync (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .d_i({twowire_data_or_select_pin_i, clock_or_host_out_pin_i,
              addr_bit0_or_serial_clock_pin_i}),
        .q_o(pins_s)
    );

    pspr_sync #(.W(2)) u_evt_sync (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .d_i({keep.wr_tgl, keep.rst_tgl}),
        .q_o({wr_tgl_s, rst_tgl_s})
    );

    always_comb begin
        next_core = core;
        next_core.pins_q = pins_s;
        next_core.wr_tgl_q = wr_tgl_s;
        next_core.rst_tgl_q = rst_tgl_s;
        next_core.wr_valid = 1'b0;
        next_core.soft_reset = 1'b0;
        // Select falling: clock low means four-wire, high means a start
        if (core.mode == pspr_pkg::PSPR_MODE_UNKNOWN &&
            core.pins_q[2] && !pins_s[2]) begin
            next_core.mode = pins_s[0] ? pspr_pkg::PSPR_MODE_TWOWIRE
                                       : pspr_pkg::PSPR_MODE_SPI;
        end
        // Written word is held stable long before its toggle arrives
        if (wr_tgl_s != core.wr_tgl_q) begin
            next_core.wr_valid = 1'b1;
            next_core.wr = keep.wr;
            if (keep.wr.addr == pspr_pkg::PAGE_REG_ADDR) begin
                next_core.page = keep.wr.data;
            end
        end
        if (rst_tgl_s != core.rst_tgl_q) begin
            next_core.soft_reset = 1'b1;
            next_core.page = pspr_pkg::PAGE_RESET;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            core <= '{pins_q: 3'h0, wr_tgl_q: 1'b0, rst_tgl_q: 1'b0,
                      mode: pspr_pkg::PSPR_MODE_UNKNOWN, wr_valid: 1'b0,
                      wr: '0, page: pspr_pkg::PAGE_RESET,
                      soft_reset: 1'b0};
        end else begin
            core <= next_core;
        end
    end

    assign wr_valid_o = core.wr_valid;
    assign wr_o = core.wr;
    assign page_o = core.page;
    assign soft_reset_o = core.soft_reset;
    assign mode_o = core.mode;
endmodule
`default_nettype wire

/* File: common/pspr_pkg.sv */
// Shared constants and types of the paged SPI register port
package pspr_pkg;
    localparam int REG_W = 8;
    localparam int ADDR_W = 7;
    localparam int PAGE_REGS = 128;
    localparam int SLOTS = 4;
    localparam int MEM_DEPTH = SLOTS * PAGE_REGS;
    localparam logic [6:0] PAGE_REG_ADDR = 7'h00;
    localparam logic [6:0] SWRST_ADDR = 7'h01;
    localparam int SWRST_BIT = 0;
    localparam int CMD_DIR_BIT = 0;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [7:0] PAGE_RESET = 8'h00;
    localparam logic [7:0] CFG_PAGE = 8'h00;
    localparam logic [7:0] COEF_PAGE_A = 8'h02;
    localparam logic [7:0] COEF_PAGE_B = 8'h03;
    localparam logic [7:0] COEF_PAGE_C = 8'h04;
    localparam logic [7:0] READ_FILL = 8'h00;

    typedef enum logic [1:0] {
        PSPR_PH_CMD,
        PSPR_PH_WR,
        PSPR_PH_RD
    } pspr_phase_t;

    typedef enum logic [1:0] {
        PSPR_MODE_UNKNOWN,
        PSPR_MODE_SPI,
        PSPR_MODE_TWOWIRE
    } pspr_mode_t;

    // One register write as seen by the rest of the device
    typedef struct packed {
        logic [7:0] page;
        logic [6:0] addr;
        logic [7:0] data;
    } pspr_wr_t;

    // Frame state, cleared whenever the select is high
    typedef struct packed {
        pspr_phase_t phase;
        logic [2:0] bitcnt;
        logic [6:0] shreg;
        logic [6:0] addr;
    } pspr_frame_t;

    // Link state that survives between frames
    typedef struct packed {
        logic [7:0] page;
        pspr_wr_t wr;
        logic wr_tgl;
        logic rst_tgl;
    } pspr_keep_t;

    typedef struct packed {
        logic [7:0] byte_sh;
        logic oe;
    } pspr_tx_t;

    typedef struct packed {
        logic [2:0] pins_q;
        logic wr_tgl_q;
        logic rst_tgl_q;
        pspr_mode_t mode;
        logic wr_valid;
        pspr_wr_t wr;
        logic [7:0] page;
        logic soft_reset;
    } pspr_core_t;
endpackage

/* File: design/pspr_sync.sv */
// Two-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module pspr_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,          // Destination clock
    input wire logic nrst_i,         // Async reset, active low
    input wire logic [W-1:0] d_i,    // Asynchronous level
    output logic [W-1:0] q_o         // Synchronised level
);
    logic [W-1:0] meta;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta <= '0;
            q_o <= '0;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule
`default_nettype wire

/* File: test/pspr_port_chk.sv */
// Checker of the paged SPI register port, bound to its ports
`timescale 1ns/1ps
`default_nettype none
module pspr_port_chk (
    input wire logic clk_i, // Core clock
    input wire logic nrst_i, // Reset, active low
    input wire logic addr_bit0_or_serial_clock_pin_i, // Serial clock
    input wire logic twowire_data_or_select_pin_i, // chip_select_n
    input wire logic addr_bit1_or_host_in_pin_o, // Host-in data
    input wire logic addr_bit1_or_host_in_pin_oe_o, // Host-in enable
    input wire logic wr_valid_o, // Write pulse
    input wire pspr_pkg::pspr_wr_t wr_o, // Write record
    input wire logic [7:0] page_o, // Current page
    input wire logic soft_reset_o, // Software reset pulse
    input wire pspr_pkg::pspr_mode_t mode_o // Protocol
);
    wire logic sclk = addr_bit0_or_serial_clock_pin_i;
    wire logic cs = twowire_data_or_select_pin_i;
    wire logic miso = addr_bit1_or_host_in_pin_o;
    wire logic oe = addr_bit1_or_host_in_pin_oe_o;
    logic [4:0] falls;
    // Falling edges seen in the current frame, saturating
    always_ff @(negedge sclk or posedge cs or negedge nrst_i) begin
        if (!nrst_i) begin
            falls <= 5'h00;
        end else if (cs) begin
            falls <= 5'h00;
        end else if (falls != 5'h1f) begin
            falls <= falls + 5'h01;
        end
    end
    wr_pulse_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        wr_valid_o |=> !wr_valid_o) else $error("write pulse too long");
    srst_pulse_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        soft_reset_o |=> !soft_reset_o) else $error("reset pulse too long");
    srst_page_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        soft_reset_o |-> ##[0:4] page_o == 8'h00) else $error("page kept");
    page_follow_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        wr_valid_o && wr_o.addr == 7'h00 |-> ##[0:4] page_o == wr_o.data)
        else $error("page not taken");
    mode_sticky_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        mode_o != pspr_pkg::PSPR_MODE_UNKNOWN |=> $stable(mode_o))
        else $error("mode changed");
    mode_detect_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $fell(cs) && !sclk && mode_o == pspr_pkg::PSPR_MODE_UNKNOWN
        |-> ##[1:8] mode_o == pspr_pkg::PSPR_MODE_SPI) else $error("no spi");
    oe_idle_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        cs |-> !oe) else $error("host-in driven while deselected");
    cmd_quiet_a: assert property (@(negedge sclk) disable iff (!nrst_i || cs)
        falls < 5'h08 |-> miso == 1'b0) else $error("data in command byte");
    oe_frame_a: assert property (@(negedge sclk) disable iff (!nrst_i || cs)
        oe) else $error("host-in not driven in frame");
    cover property (@(posedge clk_i) wr_valid_o && wr_o.addr == 7'h00);
    cover property (@(posedge clk_i) soft_reset_o);
    cover property (@(negedge sclk) falls == 5'h18);
    cover property (@(posedge clk_i) mode_o == pspr_pkg::PSPR_MODE_TWOWIRE);
endmodule
bind pspr_port pspr_port_chk i_chk (.clk_i, .nrst_i,
    .addr_bit0_or_serial_clock_pin_i, .twowire_data_or_select_pin_i,
    .addr_bit1_or_host_in_pin_o, .addr_bit1_or_host_in_pin_oe_o,
    .wr_valid_o, .wr_o, .page_o, .soft_reset_o, .mode_o);
`default_nettype wire

/* File: test/pspr_host.sv */
// Host-side SPI master model, clock idle low, sample on falling edge
`timescale 1ns/1ps
`default_nettype none
module pspr_host (
    output logic sclk_o, // Serial clock
    output logic cs_n_o, // chip_select_n
    output logic mosi_o, // Host-out data
    input wire logic miso_i // Host-in data
);
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end
    // Frame of n bytes, d[31:24] first; clock runs only inside the frame
    task automatic xfer(input int n, input logic [31:0] d,
                        output logic [31:0] q);
        q = 32'h00000000;
        #2.3 cs_n_o = 1'b0;
        for (int i = 0; i < 8 * n; i++) begin
            #7.5 sclk_o = 1'b1;
            mosi_o = d[31 - i];
            #7.5 sclk_o = 1'b0;
            q = {q[30:0], miso_i};
        end
        #7.5 cs_n_o = 1'b1;
        mosi_o = ~mosi_o;
    endtask
    // Select falls while the clock pin is high, as a two-wire start would
    task automatic probe_twowire();
        #2.3 sclk_o = 1'b1;
        #7.5 cs_n_o = 1'b0;
        #15 cs_n_o = 1'b1;
        #7.5 sclk_o = 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: test/pspr_port_tb_top.sv */
// Self-checking bench of the paged SPI register port
`timescale 1ns/1ps
`default_nettype none
module pspr_port_tb_top;
    logic clk_i, nrst_i, sclk, cs_n, mosi, miso_pin, miso_oe, wr_valid, srst;
    wire logic miso;
    pspr_pkg::pspr_wr_t wr, last_wr;
    logic [7:0] page;
    pspr_pkg::pspr_mode_t mode;
    logic [31:0] q;
    int n_fail = 0;
    int total_checks = 0;
    int n_wr = 0;
    int n_srst = 0;
    int cyc = 0;
    // Undriven line shows the opposite of the host-in pin, which select high clears to 0
    assign miso = miso_oe ? miso_pin : ~miso_pin;
    pspr_host i_host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi),
        .miso_i(miso));
    pspr_port i_dut (.clk_i(clk_i), .nrst_i(nrst_i),
        .addr_bit0_or_serial_clock_pin_i(sclk),
        .twowire_data_or_select_pin_i(cs_n), .clock_or_host_out_pin_i(mosi),
        .addr_bit1_or_host_in_pin_o(miso_pin),
        .addr_bit1_or_host_in_pin_oe_o(miso_oe), .wr_valid_o(wr_valid),
        .wr_o(wr), .page_o(page), .soft_reset_o(srst), .mode_o(mode));
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    task automatic final_report();
        if (n_fail == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (wr_valid === 1'b1) begin
            n_wr++;
            last_wr <= wr;
        end
        if (srst === 1'b1) n_srst++;
        if (cyc == 20000) begin
            n_fail++;
            final_report();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wrf(input logic [6:0] a, input logic [7:0] d);
        i_host.xfer(2, {a, 1'b0, d, 16'h0000}, q);
        repeat (10) @(posedge clk_i);
    endtask
    task automatic rdf(input int n, input logic [6:0] a);
        i_host.xfer(n, {a, 1'b1, 24'h000000}, q);
        repeat (10) @(posedge clk_i);
    endtask
    task automatic t_write();
        int n0;
        n0 = n_wr;
        chk(32'(page), 0);
        wrf(7'h05, 8'ha5);
        chk(n_wr - n0, 1);
        chk(32'(last_wr), 32'({8'h00, 7'h05, 8'ha5}));
        chk(32'(mode), 32'(pspr_pkg::PSPR_MODE_SPI));
        i_host.xfer(4, {7'h10, 1'b0, 24'h112233}, q);
        repeat (10) @(posedge clk_i);
        chk(n_wr - n0, 4);
        chk(32'(last_wr), 32'({8'h00, 7'h12, 8'h33}));
        rdf(4, 7'h10);
        chk(q, 32'h00112233);
    endtask
    task automatic t_pages();
        for (int p = 2; p <= 4; p++) begin
            wrf(7'h00, 8'(p));
            chk(32'(page), p);
            wrf(7'h7f, ~8'(p));
        end
        for (int p = 2; p <= 4; p++) begin
            wrf(7'h00, 8'(p));
            rdf(3, 7'h7f);
            chk(q, {16'h0000, ~8'(p), 8'(p)});
        end
        wrf(7'h00, 8'h00);
        rdf(2, 7'h05);
        chk(q, 32'h000000a5);
    endtask
    task automatic do_reset();
        nrst_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic t_mode();
        wrf(7'h00, 8'h03);
        chk(32'(page), 3);
        do_reset();
        chk(32'(page), 0);
        chk(32'(mode), 32'(pspr_pkg::PSPR_MODE_UNKNOWN));
        i_host.probe_twowire();
        repeat (10) @(posedge clk_i);
        chk(32'(mode), 32'(pspr_pkg::PSPR_MODE_TWOWIRE));
        rdf(2, pspr_pkg::PAGE_REG_ADDR);
        chk(q, 32'h00000000);
    endtask
    task automatic t_srst();
        int n0;
        n0 = n_srst;
        wrf(7'h00, 8'h03);
        wrf(7'h01, 8'h01);
        chk(n_srst - n0, 0);
        chk(32'(page), 3);
        wrf(7'h00, 8'h00);
        wrf(7'h01, 8'h01);
        chk(n_srst - n0, 1);
        chk(32'(page), 0);
    endtask
    initial begin
        nrst_i = 1'b0;
        repeat (6) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        t_write();
        t_pages();
        t_mode();
        t_srst();
        final_report();
    end
endmodule
`default_nettype wire
